// file: core/dpsem_host_pkg.sv
// Constants, register map and state codes for the dual-port semaphore and mailbox host.
package dpsem_host_pkg;

	localparam int DATA_W  = 36;
	localparam int LANES   = 4;
	localparam int LATCHES = 8;

	// Host register map, byte addresses of aligned 32-bit words.
	localparam logic [4:0] CTRL_OFS     = 5'h00;
	localparam logic [4:0] ADDR_OFS     = 5'h04;
	localparam logic [4:0] WDATA_LO_OFS = 5'h08;
	localparam logic [4:0] WDATA_HI_OFS = 5'h0C;
	localparam logic [4:0] RDATA_LO_OFS = 5'h10;
	localparam logic [4:0] RDATA_HI_OFS = 5'h14;
	localparam logic [4:0] STATUS_OFS   = 5'h18;

	// Control word fields.
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_OP_LSB    = 1;
	localparam int CTRL_LANE_LSB  = 4;
	localparam int CTRL_ABORT_BIT = 8;

	// Status word fields.
	localparam int STAT_BUSY_BIT    = 0;
	localparam int STAT_GRANT_BIT   = 1;
	localparam int STAT_CONTEND_BIT = 2;
	localparam int STAT_MBOX_BIT    = 3;
	localparam int STAT_OWNED_LSB   = 8;

	// Timing, in nanoseconds at a 100 ns clock.
	localparam int CLK_PERIOD_NS     = 100;
	localparam int RECOVERY_GAP_NS   = 100;
	localparam int STROBE_WIDTH_NS   = 100;
	localparam int RECOVERY_GAP_CYC  = (RECOVERY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_WIDTH_CYC  = (STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	typedef enum logic [2:0] {
		OP_MEM_WRITE = 3'h0,
		OP_MEM_READ  = 3'h1,
		OP_SEM_REQ   = 3'h2,
		OP_SEM_REL   = 3'h3,
		OP_SEM_READ  = 3'h4,
		OP_MBOX_SEND = 3'h5,
		OP_MBOX_READ = 3'h6,
		OP_NONE      = 3'h7
	} op_e;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_SETUP   = 3'h1,
		ST_STROBE  = 3'h2,
		ST_RELEASE = 3'h3,
		ST_GAP     = 3'h4
	} state_e;

endpackage : dpsem_host_pkg

// file: core/dpsem_host.sv
// Host controller driving the left port of a dual-port RAM with semaphores and mailboxes.
//
// Behaviour
// - To claim a latch, write zero to it, then read it back.
// - Between latch write and read-back, drop select and enable for the gap.
// - Read-back 0 means owned; read-back 1 means held elsewhere, keep polling.
// - Latch select acts as chip select; memory select stays inactive for latch access.
`timescale 1ns/1ps

module dpsem_host #(
	parameter int ADDR_W = 14
) (
	input  wire logic                           mclk,
	input  wire logic                           rst_n,
	input  wire logic [4:0]                     avs_address,
	input  wire logic                           avs_read,
	input  wire logic                           avs_write,
	input  wire logic [31:0]                    avs_writedata,
	output logic      [31:0]                    avs_readdata,
	output logic                                avs_waitrequest,
	output logic      [ADDR_W-1:0]              dp_addr,
	output logic      [dpsem_host_pkg::DATA_W-1:0] dp_data_o,
	input  wire logic [dpsem_host_pkg::DATA_W-1:0] dp_data_i,
	output logic                                dp_data_oe,
	output logic                                dp_ce_n,
	output logic                                dp_rw,
	output logic                                dp_oe_n,
	output logic      [dpsem_host_pkg::LANES-1:0] dp_lane_select_n,
	output logic                                dp_latch_select_n,
	input  wire logic                           dp_int_n,
	input  wire logic                           dp_busy_n
);
	import dpsem_host_pkg::*;

	// Own mailbox is the second-top word, the opposite one the top word.
	localparam logic [ADDR_W-1:0] MBOX_OTHER = {ADDR_W{1'b1}};
	localparam logic [ADDR_W-1:0] MBOX_OWN   = {{(ADDR_W-1){1'b1}}, 1'b0};
	localparam logic [7:0] GAP_CNT    = 8'(RECOVERY_GAP_CYC);
	localparam logic [7:0] STROBE_CNT = 8'(STROBE_WIDTH_CYC);

	state_e                state_r, state_nxt;
	op_e                   op_r, op_nxt;
	logic                  phase_wr_r, phase_wr_nxt;
	logic [7:0]            cnt_r, cnt_nxt;
	logic                  abort_r, abort_nxt;
	logic                  grant_r, grant_nxt;
	logic                  contend_r, contend_nxt;
	logic [LATCHES-1:0]    owned_r, owned_nxt;
	logic [ADDR_W-1:0]     cfg_addr_r, cfg_addr_nxt;
	logic [DATA_W-1:0]     wdata_r, wdata_nxt;
	logic [DATA_W-1:0]     rdata_r, rdata_nxt;
	logic [31:0]           readdata_r, readdata_nxt;
	logic                  waitreq_r, waitreq_nxt;
	logic [ADDR_W-1:0]     addr_r, addr_nxt;
	logic [DATA_W-1:0]     dout_r, dout_nxt;
	logic                  doe_r, doe_nxt;
	logic                  ce_n_r, ce_n_nxt;
	logic                  rw_r, rw_nxt;
	logic                  oe_n_r, oe_n_nxt;
	logic [LANES-1:0]      lane_n_r, lane_n_nxt;
	logic [LANES-1:0]      lane_n_cfg_r, lane_n_cfg_nxt;
	logic                  sem_n_r, sem_n_nxt;
	logic                  acc_sem;
	logic                  bus_wr;
	logic [31:0]           status_word;
	logic [2:0]            sem_idx;

	assign acc_sem = (op_r == OP_SEM_REQ) || (op_r == OP_SEM_REL) || (op_r == OP_SEM_READ);
	assign bus_wr  = avs_write && !waitreq_r;
	assign sem_idx = cfg_addr_r[2:0];

	always_comb begin
		status_word = RESET_WORD;
		status_word[STAT_BUSY_BIT] = (state_r != ST_IDLE);
		status_word[STAT_GRANT_BIT] = grant_r;
		status_word[STAT_CONTEND_BIT] = contend_r;
		status_word[STAT_MBOX_BIT] = !dp_int_n;
		status_word[STAT_OWNED_LSB +: LATCHES] = owned_r;
	end

	always_comb begin
		state_nxt = state_r;
		op_nxt = op_r;
		phase_wr_nxt = phase_wr_r;
		cnt_nxt = cnt_r;
		abort_nxt = abort_r;
		grant_nxt = grant_r;
		contend_nxt = contend_r;
		owned_nxt = owned_r;
		cfg_addr_nxt = cfg_addr_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		readdata_nxt = readdata_r;
		waitreq_nxt = 1'b1;
		addr_nxt = addr_r;
		dout_nxt = dout_r;
		doe_nxt = doe_r;
		ce_n_nxt = ce_n_r;
		rw_nxt = rw_r;
		oe_n_nxt = oe_n_r;
		lane_n_nxt = lane_n_r;
		lane_n_cfg_nxt = lane_n_cfg_r;
		sem_n_nxt = sem_n_r;

		// One wait cycle, then a single-cycle acknowledge with read data already standing.
		if ((avs_read || avs_write) && waitreq_r) begin
			waitreq_nxt = 1'b0;
			unique case (avs_address)
				ADDR_OFS:     readdata_nxt = 32'(cfg_addr_r);
				WDATA_LO_OFS: readdata_nxt = wdata_r[31:0];
				WDATA_HI_OFS: readdata_nxt = {28'h000_0000, wdata_r[DATA_W-1:32]};
				RDATA_LO_OFS: readdata_nxt = rdata_r[31:0];
				RDATA_HI_OFS: readdata_nxt = {28'h000_0000, rdata_r[DATA_W-1:32]};
				STATUS_OFS:   readdata_nxt = status_word;
				default:      readdata_nxt = RESET_WORD;
			endcase
		end

		if (bus_wr) begin
			unique case (avs_address)
				ADDR_OFS:     cfg_addr_nxt = avs_writedata[ADDR_W-1:0];
				WDATA_LO_OFS: wdata_nxt[31:0] = avs_writedata;
				WDATA_HI_OFS: wdata_nxt[DATA_W-1:32] = avs_writedata[3:0];
				CTRL_OFS: begin
					if (state_r == ST_IDLE && avs_writedata[CTRL_START_BIT]) begin
						op_nxt = op_e'(avs_writedata[CTRL_OP_LSB +: 3]);
						abort_nxt = 1'b0;
						grant_nxt = 1'b0;
						contend_nxt = 1'b0;
						// An empty lane mask would make a chip-enabled access with no lane selected.
						if (avs_writedata[CTRL_LANE_LSB +: LANES] == 4'h0) begin
							lane_n_cfg_nxt = 4'h0;
						end else begin
							lane_n_cfg_nxt = ~avs_writedata[CTRL_LANE_LSB +: LANES];
						end
					end else if (state_r != ST_IDLE && avs_writedata[CTRL_ABORT_BIT]) begin
						abort_nxt = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		unique case (state_r)
			ST_IDLE: begin
				if (op_nxt != OP_NONE && op_r == OP_NONE) begin
					state_nxt = ST_SETUP;
					phase_wr_nxt = (op_nxt == OP_MEM_WRITE) || (op_nxt == OP_SEM_REQ) ||
						(op_nxt == OP_SEM_REL) || (op_nxt == OP_MBOX_SEND);
					unique case (op_nxt)
						OP_SEM_REQ, OP_SEM_REL, OP_SEM_READ: begin
							addr_nxt = {{(ADDR_W-3){1'b0}}, cfg_addr_nxt[2:0]};
							sem_n_nxt = 1'b0;
							ce_n_nxt = 1'b1;
							lane_n_nxt = 4'hF;
							dout_nxt = {{(DATA_W-1){1'b0}}, (op_nxt == OP_SEM_REL)};
						end
						OP_MBOX_SEND, OP_MBOX_READ: begin
							addr_nxt = (op_nxt == OP_MBOX_SEND) ? MBOX_OTHER : MBOX_OWN;
							ce_n_nxt = 1'b0;
							lane_n_nxt = 4'h0;
							dout_nxt = wdata_nxt;
						end
						default: begin
							addr_nxt = cfg_addr_nxt;
							ce_n_nxt = 1'b0;
							lane_n_nxt = lane_n_cfg_nxt;
							dout_nxt = wdata_nxt;
						end
					endcase
					doe_nxt = phase_wr_nxt;
					cnt_nxt = STROBE_CNT;
				end
			end
			ST_SETUP: begin
				state_nxt = ST_STROBE;
				rw_nxt = !phase_wr_r;
				oe_n_nxt = phase_wr_r;
			end
			ST_STROBE: begin
				if (cnt_r > 8'h01) begin
					cnt_nxt = cnt_r - 8'h01;
				end else begin
					// The strobe ends one cycle before the selects drop.
					// The device then sees the write edge while its select still stands.
					state_nxt = ST_RELEASE;
					rw_nxt = 1'b1;
					oe_n_nxt = 1'b1;
					if (!phase_wr_r) begin
						rdata_nxt = dp_data_i;
					end
					if (!dp_busy_n) begin
						contend_nxt = 1'b1;
					end
				end
			end
			ST_RELEASE: begin
				rw_nxt = 1'b1;
				oe_n_nxt = 1'b1;
				sem_n_nxt = 1'b1;
				ce_n_nxt = 1'b1;
				lane_n_nxt = 4'hF;
				doe_nxt = 1'b0;
				state_nxt = ST_IDLE;
				op_nxt = OP_NONE;
				if (op_r == OP_SEM_REQ) begin
					if (phase_wr_r) begin
						state_nxt = ST_GAP;
						op_nxt = op_r;
						cnt_nxt = GAP_CNT;
					end else if (!rdata_r[0]) begin
						owned_nxt[sem_idx] = 1'b1;
						grant_nxt = 1'b1;
					end else if (!abort_r) begin
						state_nxt = ST_GAP;
						op_nxt = op_r;
						cnt_nxt = GAP_CNT;
					end
				end else if (op_r == OP_SEM_REL) begin
					owned_nxt[sem_idx] = 1'b0;
				end else if (op_r == OP_SEM_READ) begin
					grant_nxt = !rdata_r[0];
				end
			end
			ST_GAP: begin
				// Select and output enable stay inactive for the whole gap.
				if (cnt_r > 8'h01) begin
					cnt_nxt = cnt_r - 8'h01;
				end else begin
					state_nxt = ST_SETUP;
					phase_wr_nxt = 1'b0;
					sem_n_nxt = 1'b0;
					cnt_nxt = STROBE_CNT;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			op_r <= OP_NONE;
			phase_wr_r <= 1'b0;
			cnt_r <= 8'h00;
			abort_r <= 1'b0;
			grant_r <= 1'b0;
			contend_r <= 1'b0;
			owned_r <= 8'h00;
			cfg_addr_r <= '0;
			wdata_r <= '0;
			rdata_r <= '0;
			readdata_r <= RESET_WORD;
			waitreq_r <= 1'b1;
			addr_r <= '0;
			dout_r <= '0;
			doe_r <= 1'b0;
			ce_n_r <= 1'b1;
			rw_r <= 1'b1;
			oe_n_r <= 1'b1;
			lane_n_r <= 4'hF;
			lane_n_cfg_r <= 4'h0;
			sem_n_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			phase_wr_r <= phase_wr_nxt;
			cnt_r <= cnt_nxt;
			abort_r <= abort_nxt;
			grant_r <= grant_nxt;
			contend_r <= contend_nxt;
			owned_r <= owned_nxt;
			cfg_addr_r <= cfg_addr_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			readdata_r <= readdata_nxt;
			waitreq_r <= waitreq_nxt;
			addr_r <= addr_nxt;
			dout_r <= dout_nxt;
			doe_r <= doe_nxt;
			ce_n_r <= ce_n_nxt;
			rw_r <= rw_nxt;
			oe_n_r <= oe_n_nxt;
			lane_n_r <= lane_n_nxt;
			lane_n_cfg_r <= lane_n_cfg_nxt;
			sem_n_r <= sem_n_nxt;
		end
	end

	assign avs_readdata = readdata_r;
	assign avs_waitrequest = waitreq_r;
	assign dp_addr = addr_r;
	assign dp_data_o = dout_r;
	assign dp_data_oe = doe_r;
	assign dp_ce_n = ce_n_r;
	assign dp_rw = rw_r;
	assign dp_oe_n = oe_n_r;
	assign dp_lane_select_n = lane_n_r;
	assign dp_latch_select_n = sem_n_r;

endmodule : dpsem_host

// file: dv/dpsem_host_chk.sv
// Assertions on the host controller's bus handshake and device pins.
`timescale 1ns/1ps
module dpsem_host_chk (
	input logic                              mclk,
	input logic                              rst_n,
	input logic                              avs_read,
	input logic                              avs_write,
	input logic                              avs_waitrequest,
	input logic [dpsem_host_pkg::DATA_W-1:0] dp_data_o,
	input logic                              dp_data_oe,
	input logic                              dp_ce_n,
	input logic                              dp_rw,
	input logic                              dp_oe_n,
	input logic [dpsem_host_pkg::LANES-1:0]  dp_lane_select_n,
	input logic                              dp_latch_select_n
);
	import dpsem_host_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence latch_wr_s; !dp_latch_select_n && !dp_rw; endsequence
	sequence latch_rd_s; !dp_latch_select_n && !dp_oe_n; endsequence
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	latch_select_a: assert property (!dp_latch_select_n |-> dp_ce_n && &dp_lane_select_n)
		else $error("memory select during latch access");
	mem_select_a: assert property (!dp_ce_n |-> dp_latch_select_n)
		else $error("illegal select combination");
	claim_readback_a: assert property (latch_wr_s ##0 !dp_data_o[0] |-> ##[2:6] latch_rd_s)
		else $error("no read-back after claim");
	recovery_gap_a: assert property (latch_wr_s |-> ##1 dp_rw ##[1:2] dp_latch_select_n)
		else $error("no recovery gap");
	latch_data_a: assert property (latch_wr_s |-> dp_data_oe && dp_data_o[DATA_W-1:1] == '0)
		else $error("latch write data wrong");
	read_dir_a: assert property (!dp_oe_n |-> dp_rw && !dp_data_oe && $past(dp_oe_n))
		else $error("read strobe wrong");
	strobe_setup_a: assert property ($fell(dp_rw) |-> $past(dp_data_oe) ##1 dp_rw)
		else $error("write strobe wrong");
endmodule : dpsem_host_chk

// file: dv/dp_device_model.sv
// Behavioural device: eight ownership latches, two mailbox flags and a sparse memory.
`timescale 1ns/1ps
module dp_device_model #(
	parameter int ADDR_W = 14
) (
	input  wire logic [ADDR_W-1:0]                 dp_addr,
	input  wire logic [dpsem_host_pkg::DATA_W-1:0] dp_data_o,
	input  wire logic                              dp_ce_n,
	input  wire logic                              dp_rw,
	input  wire logic                              dp_oe_n,
	input  wire logic [dpsem_host_pkg::LANES-1:0]  dp_lane_select_n,
	input  wire logic                              dp_latch_select_n,
	input  wire logic                              dp_busy_n,
	output logic      [dpsem_host_pkg::DATA_W-1:0] dp_data_i,
	output logic                                   dp_int_n
);
	import dpsem_host_pkg::*;
	localparam logic [ADDR_W-1:0] TOP = '1;
	logic [1:0]         owner [LATCHES];
	logic [LATCHES-1:0] pend [3];
	logic [DATA_W-1:0]  mem [logic [ADDR_W-1:0]];
	logic [DATA_W-1:0]  out_q, last_q;
	logic               int_r_n;
	initial begin
		foreach (owner[i]) owner[i] = 2'h0;
		foreach (pend[i]) pend[i] = '0;
		{dp_int_n, int_r_n, out_q, last_q} = {2'h3, {2*DATA_W{1'b0}}};
	end
	// Owner code 1 is the left port, 2 the right; a blocked claim waits in pend.
	task automatic sem_write(input logic [1:0] me, input int i, input logic v);
		logic [1:0] other;
		other = 2'h3 - me;
		if (!v && owner[i] == 2'h0) owner[i] = me;
		else if (!v && owner[i] != me) pend[me][i] = 1'b1;
		else if (v && owner[i] == me) begin
			owner[i] = pend[other][i] ? other : 2'h0;
			pend[other][i] = 1'b0;
		end else if (v) pend[me][i] = 1'b0;
	endtask : sem_write
	always @(posedge dp_rw) begin
		if (dp_latch_select_n === 1'b0) sem_write(2'h1, int'(dp_addr[2:0]), dp_data_o[0]);
		else if (dp_ce_n === 1'b0) begin
			if (!mem.exists(dp_addr)) mem[dp_addr] = '0;
			for (int k = 0; k < LANES; k++)
				if (!dp_lane_select_n[k]) mem[dp_addr][9*k +: 9] = dp_data_o[9*k +: 9];
			if (dp_addr == TOP && dp_busy_n) int_r_n = 1'b0;
		end
	end
	// Read data is frozen when the strobe falls, so a later claim cannot disturb it.
	always @(negedge dp_oe_n) begin
		out_q = ~last_q;
		if (dp_latch_select_n === 1'b0) out_q[8:0] = {9{owner[dp_addr[2:0]] != 2'h1}};
		else if (dp_ce_n === 1'b0) begin
			for (int k = 0; k < LANES; k++)
				if (!dp_lane_select_n[k] && mem.exists(dp_addr)) out_q[9*k +: 9] = mem[dp_addr][9*k +: 9];
			if (dp_addr == TOP - 1'b1 && dp_busy_n) dp_int_n = 1'b1;
		end
	end
	always @(posedge dp_oe_n) last_q = out_q;
	assign dp_data_i = (dp_oe_n === 1'b0) ? out_q : ~last_q;
	task automatic right_sem(input int i, input logic v);
		sem_write(2'h2, i, v);
	endtask : right_sem
	task automatic right_mbox(input logic wr);
		if (wr) dp_int_n = 1'b0;
		else int_r_n = 1'b1;
	endtask : right_mbox
endmodule : dp_device_model

// file: dv/testbench.sv
// Self-checking bench for the semaphore and mailbox host controller.
`timescale 1ns/1ps
module testbench;
	import dpsem_host_pkg::*;
	logic              mclk, rst_n, avs_read, avs_write, avs_waitrequest, dp_busy_n, dp_int_n;
	logic              dp_data_oe, dp_ce_n, dp_rw, dp_oe_n, dp_latch_select_n;
	logic [4:0]        avs_address;
	logic [31:0]       avs_writedata, avs_readdata, rd;
	logic [13:0]       dp_addr;
	logic [DATA_W-1:0] dp_data_o, dp_data_i;
	logic [LANES-1:0]  dp_lane_select_n;
	int                bad_count = 0;
	int                tests_run = 0;
	dpsem_host dpsem_host_i (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dp_addr(dp_addr),
		.dp_data_o(dp_data_o), .dp_data_i(dp_data_i), .dp_data_oe(dp_data_oe), .dp_ce_n(dp_ce_n),
		.dp_rw(dp_rw), .dp_oe_n(dp_oe_n), .dp_lane_select_n(dp_lane_select_n),
		.dp_latch_select_n(dp_latch_select_n), .dp_int_n(dp_int_n), .dp_busy_n(dp_busy_n));
	dp_device_model dp_device_model_i (.dp_addr(dp_addr), .dp_data_o(dp_data_o),
		.dp_ce_n(dp_ce_n), .dp_rw(dp_rw), .dp_oe_n(dp_oe_n), .dp_lane_select_n(dp_lane_select_n),
		.dp_latch_select_n(dp_latch_select_n), .dp_busy_n(dp_busy_n), .dp_data_i(dp_data_i),
		.dp_int_n(dp_int_n));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic tally_and_finish();
		if (bad_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic check(input logic [35:0] seen, input logic [35:0] want);
		tests_run++;
		if (seen !== want) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
		if (n >= 20) begin
			bad_count++;
			tally_and_finish();
		end
	endtask : bus
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			bus(1'b0, STATUS_OFS, 32'h0);
			n++;
		end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 40);
		check(rd[STAT_BUSY_BIT], 1'b0);
		if (n >= 40) begin
			tally_and_finish();
		end
	endtask : wait_idle
	task automatic op(input op_e o, input logic [3:0] ln, input logic [31:0] a,
		input logic [31:0] d, input logic w);
		bus(1'b1, ADDR_OFS, a);
		bus(1'b1, WDATA_LO_OFS, d);
		bus(1'b1, CTRL_OFS, {23'h0, 1'b0, ln, o, 1'b1});
		if (w) wait_idle();
	endtask : op
	task automatic reset_scn();
		bus(1'b0, STATUS_OFS, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, 5'h1C, 32'h0);
		check(rd, 32'h0);
		op(OP_SEM_READ, 4'h0, 32'h3, 32'h0, 1'b1);
		check(rd, 32'h0);
	endtask : reset_scn
	task automatic claim_scn();
		op(OP_SEM_REQ, 4'h0, 32'h0000_3FFD, 32'h0, 1'b1);
		check(rd, 32'h0000_2002);
		dp_device_model_i.right_sem(5, 1'b0);
		check(dp_device_model_i.owner[5], 2'h1);
		op(OP_SEM_REL, 4'h0, 32'h5, 32'h0, 1'b1);
		check(rd[15:8], 8'h0);
		check(dp_device_model_i.owner[5], 2'h2);
		dp_device_model_i.right_sem(5, 1'b1);
		check(dp_device_model_i.owner[5], 2'h0);
	endtask : claim_scn
	task automatic poll_scn();
		dp_device_model_i.right_sem(2, 1'b0);
		op(OP_SEM_REQ, 4'h0, 32'h2, 32'h0, 1'b0);
		repeat (12) @(posedge mclk);
		bus(1'b0, STATUS_OFS, 32'h0);
		check(rd[1:0], 2'h1);
		dp_device_model_i.right_sem(2, 1'b1);
		wait_idle();
		check(rd[15:0], 16'h0402);
		op(OP_SEM_REL, 4'h0, 32'h2, 32'h0, 1'b1);
	endtask : poll_scn
	task automatic mbox_scn();
		op(OP_MBOX_SEND, 4'h0, 32'h0, 32'hA5A5_5A5A, 1'b1);
		check(dp_device_model_i.int_r_n, 1'b0);
		op(OP_MEM_READ, 4'h0, 32'h0000_3FFF, 32'h0, 1'b1);
		check(dp_device_model_i.int_r_n, 1'b0);
		dp_device_model_i.right_mbox(1'b0);
		dp_device_model_i.right_mbox(1'b1);
		dp_busy_n <= 1'b0;
		op(OP_MBOX_SEND, 4'h0, 32'h0, 32'h1, 1'b1);
		check(dp_device_model_i.int_r_n, 1'b1);
		op(OP_MBOX_READ, 4'h0, 32'h0, 32'h0, 1'b1);
		check(rd[3:2], 2'h3);
		dp_busy_n <= 1'b1;
		op(OP_MBOX_READ, 4'h0, 32'h0, 32'h0, 1'b1);
		check(rd[3], 1'b0);
	endtask : mbox_scn
	task automatic lane_scn();
		op(OP_MEM_WRITE, 4'h0, 32'h10, 32'hFFFF_FFFF, 1'b1);
		op(OP_MEM_WRITE, 4'h5, 32'h10, 32'h0, 1'b1);
		op(OP_MEM_READ, 4'h0, 32'h10, 32'h0, 1'b1);
		bus(1'b0, RDATA_LO_OFS, 32'h0);
		check(rd, 32'hF803_FE00);
		op(OP_MEM_READ, 4'h2, 32'h10, 32'h0, 1'b1);
		bus(1'b0, RDATA_LO_OFS, 32'h0);
		check(rd[17:9], 9'h1FF);
	endtask : lane_scn
	initial begin
		{rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
		dp_busy_n = 1'b1;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		reset_scn();
		claim_scn();
		poll_scn();
		mbox_scn();
		lane_scn();
		tally_and_finish();
	end
endmodule : testbench
bind dpsem_host dpsem_host_chk dpsem_host_chk_i (.mclk(mclk), .rst_n(rst_n),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.dp_data_o(dp_data_o), .dp_data_oe(dp_data_oe), .dp_ce_n(dp_ce_n), .dp_rw(dp_rw),
	.dp_oe_n(dp_oe_n), .dp_lane_select_n(dp_lane_select_n),
	.dp_latch_select_n(dp_latch_select_n));
